// >>> eig_pkg.sv
package eig_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int REQ_N   = 4;
  localparam int GP_N    = 3;
  localparam int SRC_N   = REQ_N + GP_N;
  localparam int EVT_N   = SRC_N + 1;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int SYNC_N  = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_FCR      = 12'h000;
  localparam logic [11:0] OFS_ISR      = 12'h004;
  localparam logic [11:0] OFS_CTRL     = 12'h008;
  localparam logic [11:0] OFS_INT_STAT = 12'h00c;
  localparam logic [11:0] OFS_INT_MASK = 12'h010;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_LOCK_BIT  = 0;
  localparam int CTRL_SUPER_BIT = 1;
  localparam int EVT_RESET_BIT  = SRC_N;

  // Function control register layout
  typedef struct packed {
    logic [GP_N-1:0]  gp_mask;
    logic [GP_N-1:0]  gp_pol;
    logic [GP_N-1:0]  gp_dir;
    logic [REQ_N-1:0] req_pol;
    logic [REQ_N-1:0] req_mask;
  } eig_fcr_t;

  localparam int FCR_W = $bits(eig_fcr_t);

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam eig_fcr_t        FCR_RST      = '{gp_mask: 3'h7, gp_pol: 3'h0, gp_dir: 3'h0,
                                               req_pol: 4'h0, req_mask: 4'hf};
  localparam logic            LOCK_RST     = 1'b1;
  localparam logic            SUPER_RST    = 1'b1;
  localparam logic [EVT_N-1:0] INT_MASK_RST = 8'h00;

endpackage : eig_pkg

// >>> eig_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// Three-stage input synchroniser with agreement filter
// ****************************************************************
module eig_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Raw and clean levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level
);
  import eig_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain, stage1 feeds stage2 only
  always_ff @(posedge mclk) begin
    stage1 <= raw;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // Level follows only where stage2 and stage3 agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

  AST_SYNC_AGREE: assert property (@(posedge mclk) disable iff (!rstn)
    ((level ^ $past(level)) & (($past(stage2) ^ $past(stage3)) | (level ^ $past(stage3)))) == '0)
    else $error("level changed without stage agreement");

endmodule : eig_sync

// >>> eig_top.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Behaviour
// - Active unmasked request with lock clear raises the interrupt exception
// - Level-select one makes high active, zero makes low active
// - Requests are plain levels, only the status bit stays latched once the pin goes inactive
// - A pin change takes effect no sooner than three clocks later
// - Input status register shows pin levels; masked pins are plain inputs
// - Each general pin direction follows its own direction bit
// - General input pins act as request sources or readable inputs
// - General output pin drives its level-select value, except the first pin when unmasked
// - First and second general pins as outputs never request interrupts
// - First pin output unmasked drives supervisor flag, inverted when select is zero
// - Reset low returns everything but the synchroniser shift chain to initial state
// - Reset release takes a reset exception toward the entry vector
module eig_top (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [eig_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [eig_pkg::DATA_W-1:0]   pwdata,
  output logic      [eig_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // External request pins
  input  wire logic [eig_pkg::REQ_N-1:0]    ext_request_pins,
  // General pins, split into in, out and enable
  input  wire logic [eig_pkg::GP_N-1:0]     general_pins_in,
  output logic      [eig_pkg::GP_N-1:0]     general_pins_out,
  output logic      [eig_pkg::GP_N-1:0]     general_pins_oe,
  // Processor side
  output logic                              irq_exception,
  output logic                              reset_exception,
  output logic                              irq
);
  import eig_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  eig_fcr_t         function_control_register;
  logic             lock_flag;
  logic             supervisor_flag;
  logic [EVT_N-1:0] int_stat;
  logic [EVT_N-1:0] int_mask;
  logic [REQ_N-1:0] req_lvl;
  logic [GP_N-1:0]  gp_lvl;
  logic [SRC_N-1:0] src_active;
  logic [SRC_N-1:0] src_prev;
  logic             rst_hold;
  logic [EVT_N-1:0] evt_set;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [DATA_W-1:0] next_rdata;

  // Address decode shared by read and write paths
  function automatic logic eig_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    eig_hit = (a == ofs);
  endfunction : eig_hit

  // Source is active when its level matches its select and it is unmasked
  function automatic logic eig_req(input logic lvl, input logic pol, input logic mask);
    eig_req = (lvl == pol) && !mask;
  endfunction : eig_req

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  eig_sync #(.WIDTH(REQ_N)) u_req_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .raw   (ext_request_pins),
    .level (req_lvl)
  );

  eig_sync #(.WIDTH(GP_N)) u_gp_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .raw   (general_pins_in),
    .level (gp_lvl)
  );

  // ****************************************************************
  // Request sources
  // ****************************************************************

  // Per-source active level, outputs on all general pins excluded
  always_comb begin
    for (int i = 0; i < REQ_N; i++) begin
      src_active[i] = eig_req(req_lvl[i], function_control_register.req_pol[i],
                              function_control_register.req_mask[i]);
    end
    for (int j = 0; j < GP_N; j++) begin
      src_active[REQ_N+j] = eig_req(gp_lvl[j], function_control_register.gp_pol[j],
                                    function_control_register.gp_mask[j])
                            && !function_control_register.gp_dir[j];
    end
  end

  // Exception level, registered from live source levels and the lock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_exception <= 1'b0;
    end else begin
      irq_exception <= (|src_active) && !lock_flag;
    end
  end

  // ****************************************************************
  // General pin drivers
  // ****************************************************************

  // Direction and driven level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      general_pins_oe  <= '0;
      general_pins_out <= '0;
    end else begin
      general_pins_oe <= function_control_register.gp_dir;
      for (int j = 0; j < GP_N; j++) begin
        general_pins_out[j] <= function_control_register.gp_pol[j];
      end
      if (function_control_register.gp_dir[0] && !function_control_register.gp_mask[0]) begin
        general_pins_out[0] <= function_control_register.gp_pol[0] ? supervisor_flag
                                                                   : !supervisor_flag;
      end
    end
  end

  // ****************************************************************
  // Reset exception
  // ****************************************************************

  // One pulse at the first edge after release
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rst_hold        <= 1'b1;
      reset_exception <= 1'b0;
    end else begin
      rst_hold        <= 1'b0;
      reset_exception <= rst_hold;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  // Events: a source turning active, and the reset exception
  always_comb begin
    evt_set                = '0;
    evt_set[SRC_N-1:0]     = src_active & ~src_prev;
    evt_set[EVT_RESET_BIT] = rst_hold;
  end

  // Previous source state for edge detection
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      src_prev <= '0;
    end else begin
      src_prev <= src_active;
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      int_stat <= '0;
    end else if (wr_en && eig_hit(paddr, OFS_INT_STAT)) begin
      int_stat <= (int_stat & ~pwdata[EVT_N-1:0]) | evt_set;
    end else begin
      int_stat <= int_stat | evt_set;
    end
  end

  // Interrupt line
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = psel && penable && !pready && !pwrite;
  assign addr_ok = eig_hit(paddr, OFS_FCR) || eig_hit(paddr, OFS_ISR) ||
                   eig_hit(paddr, OFS_CTRL) || eig_hit(paddr, OFS_INT_STAT) ||
                   eig_hit(paddr, OFS_INT_MASK);

  // Read mux
  always_comb begin
    next_rdata = '0;
    if (eig_hit(paddr, OFS_FCR)) begin
      next_rdata[FCR_W-1:0] = function_control_register;
    end else if (eig_hit(paddr, OFS_ISR)) begin
      next_rdata[SRC_N-1:0] = {gp_lvl, req_lvl};
    end else if (eig_hit(paddr, OFS_CTRL)) begin
      next_rdata[CTRL_LOCK_BIT]  = lock_flag;
      next_rdata[CTRL_SUPER_BIT] = supervisor_flag;
    end else if (eig_hit(paddr, OFS_INT_STAT)) begin
      next_rdata[EVT_N-1:0] = int_stat;
    end else if (eig_hit(paddr, OFS_INT_MASK)) begin
      next_rdata[EVT_N-1:0] = int_mask;
    end
  end

  // Ready one cycle into the access phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
    end
  end

  // Read data capture
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (rd_en) begin
      prdata <= next_rdata;
    end else begin
      prdata <= '0;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      function_control_register <= FCR_RST;
      lock_flag                 <= LOCK_RST;
      supervisor_flag           <= SUPER_RST;
      int_mask                  <= INT_MASK_RST;
    end else if (wr_en) begin
      if (eig_hit(paddr, OFS_FCR)) begin
        function_control_register <= pwdata[FCR_W-1:0];
      end
      if (eig_hit(paddr, OFS_CTRL)) begin
        lock_flag       <= pwdata[CTRL_LOCK_BIT];
        supervisor_flag <= pwdata[CTRL_SUPER_BIT];
      end
      if (eig_hit(paddr, OFS_INT_MASK)) begin
        int_mask <= pwdata[EVT_N-1:0];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_LOCK_BLOCKS: assert property (@(posedge mclk) disable iff (!rstn)
    lock_flag |=> !irq_exception)
    else $error("exception raised while lock set");

  AST_POL_HIGH: assert property (@(posedge mclk) disable iff (!rstn)
    (!lock_flag && !function_control_register.req_mask[0] &&
     req_lvl[0] == function_control_register.req_pol[0]) |=> irq_exception)
    else $error("selected level did not raise exception");

  AST_NO_LATCH: assert property (@(posedge mclk) disable iff (!rstn)
    (src_active == '0) |=> !irq_exception)
    else $error("exception held with no active source");

  AST_GP_DIR: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 general_pins_oe == $past(function_control_register.gp_dir))
    else $error("pin enable differs from direction bit");

  AST_GP_DRIVE: assert property (@(posedge mclk) disable iff (!rstn)
    function_control_register.gp_dir[2] |=>
      general_pins_out[2] == $past(function_control_register.gp_pol[2]))
    else $error("output pin level differs from select");

  AST_OUT_NO_IRQ: assert property (@(posedge mclk) disable iff (!rstn)
    (function_control_register.gp_dir[1:0] == 2'b11 && src_active[REQ_N-1:0] == '0 &&
     !src_active[REQ_N+2]) |=> !irq_exception)
    else $error("output pin became a request source");

  AST_SUPER_OUT: assert property (@(posedge mclk) disable iff (!rstn)
    (function_control_register.gp_dir[0] && !function_control_register.gp_mask[0]) |=>
      general_pins_out[0] == ($past(function_control_register.gp_pol[0]) ~^ $past(supervisor_flag)))
    else $error("supervisor flag not on first pin");

  AST_RESET_QUIET: assert property (@(posedge mclk)
    !rstn |=> (!irq_exception && !irq && general_pins_oe == '0 && !reset_exception))
    else $error("outputs active during reset");

  AST_RST_EXC: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rstn) |=> reset_exception ##1 !reset_exception)
    else $error("reset exception not a single pulse");

  AST_STICKY_SET: assert property (@(posedge mclk) disable iff (!rstn)
    evt_set[0] |=> int_stat[0])
    else $error("event lost from status");

  // Pin path latency, measured from the raw pins
  AST_REQ_LATENCY: assert property (@(posedge mclk) disable iff (!rstn)
    ((req_lvl ^ $past(req_lvl)) & (req_lvl ^ $past(ext_request_pins, 4))) == '0)
    else $error("request level moved before three cycles");

  // General input pin as a request source
  AST_GP_IN_REQ: assert property (@(posedge mclk) disable iff (!rstn)
    (!lock_flag && !function_control_register.gp_dir[2] && !function_control_register.gp_mask[2] &&
     gp_lvl[2] == function_control_register.gp_pol[2]) |=> irq_exception)
    else $error("general input did not raise exception");

  AST_GP_DRIVE1: assert property (@(posedge mclk) disable iff (!rstn)
    function_control_register.gp_dir[1] |=>
      general_pins_out[1] == $past(function_control_register.gp_pol[1]))
    else $error("second output pin level differs from select");

  AST_RESET_STAT: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rstn) |=> int_stat[EVT_RESET_BIT])
    else $error("reset exception not recorded in status");

  // Cover points for the main scenarios
  COV_GP_REQ: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(int_stat[REQ_N]));
  COV_EXC: cover property (@(posedge mclk) disable iff (!rstn)
    !irq_exception ##1 irq_exception);
  COV_SUPER: cover property (@(posedge mclk) disable iff (!rstn)
    function_control_register.gp_dir[0] && !function_control_register.gp_mask[0] && $changed(general_pins_out[0]));
  COV_IRQ: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(irq));
  COV_RST: cover property (@(posedge mclk)
    $rose(reset_exception));

endmodule : eig_top

// >>> eig_pin_src.sv
`timescale 1ns/1ps

// ****************************************************************
// External interrupt sources and general pin peripheral
// ****************************************************************
module eig_pin_src #(
  parameter int DLY = 13
) (
  // Levels chosen by the bench
  input  wire logic [eig_pkg::REQ_N-1:0] req_level,
  input  wire logic [eig_pkg::GP_N-1:0]  gp_drive,
  // Device side of the general pins
  input  wire logic [eig_pkg::GP_N-1:0]  gp_out,
  input  wire logic [eig_pkg::GP_N-1:0]  gp_oe,
  // Levels seen by the device
  output logic      [eig_pkg::REQ_N-1:0] ext_request_pins,
  output logic      [eig_pkg::GP_N-1:0]  general_pins_in
);
  import eig_pkg::*;
  logic [GP_N-1:0] src;

  // Sources move off the clock grid, levels only
  initial ext_request_pins = '0;
  initial src = '0;
  always @(req_level) ext_request_pins <= #DLY req_level;
  always @(gp_drive) src <= #DLY gp_drive;

  // Wire level: device wins where it drives
  assign general_pins_in = (gp_oe & gp_out) | (~gp_oe & src);
endmodule : eig_pin_src

// >>> ext_irq_gpio_reset_logic_tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Bench top
// ****************************************************************
module ext_irq_gpio_reset_logic_tb;
  import eig_pkg::*;
  logic                mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, rd;
  logic [REQ_N-1:0]    ext_request_pins, req_level;
  logic [GP_N-1:0]     gp_in, gp_out, gp_oe, gp_drive;
  logic                irq_exception, reset_exception, irq, er;
  int                  bad_count, checked;
  eig_fcr_t            f;

  eig_top u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_request_pins(ext_request_pins), .general_pins_in(gp_in), .general_pins_out(gp_out),
    .general_pins_oe(gp_oe), .irq_exception(irq_exception), .reset_exception(reset_exception),
    .irq(irq));

  eig_pin_src u_src (.req_level(req_level), .gp_drive(gp_drive), .gp_out(gp_out), .gp_oe(gp_oe),
    .ext_request_pins(ext_request_pins), .general_pins_in(gp_in));

  // Clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk(1'b0, 1'b1);
      finish_test();
    end
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask : rdc

  // Request pin with one level select, lock and mask
  task automatic req_case(input int i, input logic p);
    logic [3:0] e;
    e = {4{~p}};
    f = FCR_RST;
    f.req_mask[i] = 1'b0;
    f.req_pol[i] = p;
    req_level <= e;
    wr(OFS_FCR, 32'(f));
    cyc(8);
    chk(irq_exception, 1'b0);
    e[i] = p;
    req_level <= e;
    cyc(3);
    chk(irq_exception, 1'b0);
    cyc(5);
    chk(irq_exception, 1'b1);
    rdc(OFS_ISR, {28'h0, e});
    wr(OFS_CTRL, 32'h1);
    cyc(6);
    chk(irq_exception, 1'b0);
    wr(OFS_CTRL, 32'h0);
    f.req_mask[i] = 1'b1;
    wr(OFS_FCR, 32'(f));
    cyc(6);
    chk(irq_exception, 1'b0);
    f.req_mask[i] = 1'b0;
    wr(OFS_FCR, 32'(f));
    req_level <= {4{~p}};
    cyc(8);
    chk(irq_exception, 1'b0);
  endtask : req_case

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Watchdog at 20000 cycles, far beyond the fewer than one thousand cycles needed
  initial begin
    #(20000 * 50);
    bad_count++;
    finish_test();
  end

  // Test sequence
  initial begin
    bad_count = 0;
    checked = 0;
    rstn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    req_level = 4'h0;
    gp_drive = 3'h0;
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    chk(reset_exception, 1'b1);
    cyc(1);
    chk(reset_exception, 1'b0);
    rdc(OFS_FCR, 32'(FCR_RST));
    rdc(OFS_CTRL, 32'h3);
    rdc(OFS_INT_STAT, 32'h80);
    apb(1'b0, 12'h014, 32'h0, rd, er);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    wr(OFS_CTRL, 32'h0);
    $display("reset test done");
    for (int i = 0; i < REQ_N; i++) begin
      req_case(i, 1'b0);
      req_case(i, 1'b1);
    end
    $display("request pin test done");
    // Sticky status, mask and clear
    f = FCR_RST;
    f.req_mask = 4'he;
    f.req_pol = 4'hf;
    wr(OFS_FCR, 32'(f));
    req_level <= 4'h0;
    cyc(8);
    wr(OFS_INT_STAT, 32'hff);
    rdc(OFS_INT_STAT, 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    req_level <= 4'h1;
    cyc(8);
    req_level <= 4'h0;
    cyc(8);
    chk(irq, 1'b1);
    wr(OFS_INT_MASK, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr(OFS_INT_STAT, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    $display("interrupt test done");
    // General pins as outputs
    for (int k = 0; k < 2; k++) begin
      f = FCR_RST;
      f.gp_dir = 3'h7;
      f.gp_pol = k ? 3'h2 : 3'h5;
      gp_drive <= ~f.gp_pol;
      wr(OFS_FCR, 32'(f));
      cyc(1);
      chk(gp_oe, 3'h7);
      chk(gp_out, f.gp_pol);
      cyc(6);
      rdc(OFS_ISR, {25'h0, f.gp_pol, 4'h0});
    end
    f.gp_mask = 3'h0;
    f.gp_pol = 3'h7;
    wr(OFS_FCR, 32'(f));
    cyc(8);
    chk(irq_exception, 1'b0);
    f.gp_dir = 3'h2;
    wr(OFS_FCR, 32'(f));
    cyc(1);
    chk(gp_oe, 3'h2);
    // Supervisor flag on the first pin
    f = FCR_RST;
    f.gp_dir = 3'h1;
    f.gp_mask = 3'h6;
    for (int s = 0; s < 4; s++) begin
      f.gp_pol[0] = s[1];
      wr(OFS_CTRL, {30'h0, s[0], 1'b0});
      wr(OFS_FCR, 32'(f));
      cyc(1);
      chk(gp_out[0], s[1] ? s[0] : !s[0]);
    end
    // First pin as an interrupt input
    f = FCR_RST;
    f.gp_mask = 3'h6;
    f.gp_pol = 3'h1;
    gp_drive <= 3'h0;
    wr(OFS_FCR, 32'(f));
    cyc(8);
    chk(irq_exception, 1'b0);
    gp_drive <= 3'h1;
    cyc(8);
    chk(irq_exception, 1'b1);
    rdc(OFS_ISR, 32'h10);
    $display("general pin test done");
    // Reset in mid-run
    f.gp_dir = 3'h7;
    wr(OFS_FCR, 32'(f));
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    chk(reset_exception, 1'b1);
    chk(gp_oe, 3'h0);
    chk(irq_exception, 1'b0);
    cyc(1);
    rdc(OFS_FCR, 32'(FCR_RST));
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : ext_irq_gpio_reset_logic_tb
